/* File: rtl/bsd_data_path.sv */
`timescale 1ns/100ps
`default_nettype none

module bsd_data_path
   import bsd_pkg::*;
#(
   parameter int N_OBS = NUM_OBS_PINS,
   parameter int N_OUT = NUM_OUT_PINS,
   parameter int N_BIDIR = NUM_BIDIR_PINS,
   parameter logic [ID_WIDTH-1:0] ID_VALUE = ID_VALUE_DEFAULT
)
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic TEST_CLK,
   input wire logic TEST_RESET_N,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   input wire logic CAPTURE_DR,
   input wire logic SHIFT_DR,
   input wire logic UPDATE_DR,
   input wire logic SHIFT_IR,
   input wire logic IR_SERIAL_OUT,
   input wire logic INSTR_EXTEST,
   input wire logic INSTR_SAMPLE,
   input wire logic INSTR_IDCODE,
   input wire logic [N_OBS-1:0] OBS_PINS,
   output logic [N_OBS-1:0] CORE_OBS_IN,
   input wire logic [N_OUT-1:0] CORE_OUT,
   output logic [N_OUT-1:0] OUT_PINS,
   input wire logic [N_BIDIR-1:0] CORE_BIDIR_OUT,
   input wire logic [N_BIDIR-1:0] CORE_BIDIR_OE,
   output logic [N_BIDIR-1:0] CORE_BIDIR_IN,
   input wire logic [N_BIDIR-1:0] BIDIR_IN,
   output logic [N_BIDIR-1:0] BIDIR_OUT,
   output logic [N_BIDIR-1:0] BIDIR_OE,
   output logic EXTEST_ACTIVE_SYS
);

   localparam int N_CELLS = N_OBS + N_OUT + 2 * N_BIDIR;
   localparam int BIDIR_BASE = N_OBS + N_OUT;

   bsd_dr_sel_e dr_sel;
   logic bsr_capture;
   logic bsr_shift;
   logic bsr_update;
   logic [N_CELLS:0] chain;
   logic [N_OUT-1:0] out_upd;
   logic [N_BIDIR-1:0] oe_upd;
   logic [N_BIDIR-1:0] dat_upd;
   logic [N_BIDIR-1:0] bidir_cap_src;
   logic bypass_q;
   logic bypass_d;
   logic [ID_WIDTH-1:0] id_q;
   logic [ID_WIDTH-1:0] id_d;
   logic tdo_q;
   logic tdo_d;
   logic tdo_oe_q;
   logic tdo_oe_d;
   logic ext_meta_q;
   logic ext_meta_d;
   logic ext_sync_q;
   logic ext_sync_d;

   // serial path selection from the current instruction
   always_comb
   begin
      if (INSTR_EXTEST || INSTR_SAMPLE)
      begin
         dr_sel = BSD_SEL_BOUNDARY;
      end
      else if (INSTR_IDCODE)
      begin
         dr_sel = BSD_SEL_IDCODE;
      end
      else
      begin
         dr_sel = BSD_SEL_BYPASS;
      end
   end

   assign bsr_capture = CAPTURE_DR && (dr_sel == BSD_SEL_BOUNDARY);
   assign bsr_shift = SHIFT_DR && (dr_sel == BSD_SEL_BOUNDARY);
   assign bsr_update = UPDATE_DR && (dr_sel == BSD_SEL_BOUNDARY);
   assign chain[0] = TDI;

   // observe-only inputs: the core always sees the pin itself
   assign CORE_OBS_IN = OBS_PINS;

   genvar gi;
   generate
      for (gi = 0; gi < N_OBS; gi++)
      begin : g_obs
         bsd_obs_cell u_cell (
            .tck(TEST_CLK),
            .trst_n(TEST_RESET_N),
            .capture_en(bsr_capture),
            .shift_en(bsr_shift),
            .data_in(OBS_PINS[gi]),
            .serial_in(chain[gi]),
            .serial_out(chain[gi+1])
         );
      end

      for (gi = 0; gi < N_OUT; gi++)
      begin : g_out
         bsd_ctl_cell u_cell (
            .tck(TEST_CLK),
            .trst_n(TEST_RESET_N),
            .capture_en(bsr_capture),
            .shift_en(bsr_shift),
            .update_en(bsr_update),
            .data_in(OUT_PINS[gi]),
            .serial_in(chain[N_OBS+gi]),
            .serial_out(chain[N_OBS+gi+1]),
            .update_out(out_upd[gi])
         );
      end

      // two cells per bidirectional pin: enable, then capture
      for (gi = 0; gi < N_BIDIR; gi++)
      begin : g_bidir
         bsd_ctl_cell u_oe (
            .tck(TEST_CLK),
            .trst_n(TEST_RESET_N),
            .capture_en(bsr_capture),
            .shift_en(bsr_shift),
            .update_en(bsr_update),
            .data_in(BIDIR_OE[gi]),
            .serial_in(chain[BIDIR_BASE+2*gi]),
            .serial_out(chain[BIDIR_BASE+2*gi+1]),
            .update_out(oe_upd[gi])
         );
         bsd_obs_cell u_cap (
            .tck(TEST_CLK),
            .trst_n(TEST_RESET_N),
            .capture_en(bsr_capture),
            .shift_en(bsr_shift),
            .data_in(bidir_cap_src[gi]),
            .serial_in(chain[BIDIR_BASE+2*gi+1]),
            .serial_out(chain[BIDIR_BASE+2*gi+2])
         );
      end
   endgenerate

   // capture cell is one register with no update latch, so in EXTEST an enabled
   // pad drives the enable latch value: a latch saved, the pad read back by capture
   assign dat_upd = oe_upd;

   // pin muxing, no clock in the path so EXTEST acts at once
   always_comb
   begin
      OUT_PINS = INSTR_EXTEST ? out_upd : CORE_OUT;
      BIDIR_OE = INSTR_EXTEST ? oe_upd : CORE_BIDIR_OE;
      BIDIR_OUT = INSTR_EXTEST ? dat_upd : CORE_BIDIR_OUT;
      CORE_BIDIR_IN = BIDIR_IN;
      for (int i = 0; i < N_BIDIR; i++)
      begin
         // core data while driving in mission mode, pad otherwise
         bidir_cap_src[i] = (BIDIR_OE[i] && !INSTR_EXTEST) ? CORE_BIDIR_OUT[i] : BIDIR_IN[i];
      end
   end

   // bypass and identification registers
   always_comb
   begin
      bypass_d = bypass_q;
      id_d = id_q;
      if (CAPTURE_DR)
      begin
         bypass_d = BYPASS_CAPTURE_VAL;
      end
      else if (SHIFT_DR && dr_sel == BSD_SEL_BYPASS)
      begin
         bypass_d = TDI;
      end
      if (CAPTURE_DR && dr_sel == BSD_SEL_IDCODE)
      begin
         id_d = ID_VALUE;
      end
      else if (SHIFT_DR && dr_sel == BSD_SEL_IDCODE)
      begin
         id_d = {TDI, id_q[ID_WIDTH-1:1]};
      end
   end

   always_ff @(posedge TEST_CLK or negedge TEST_RESET_N)
   begin
      if (!TEST_RESET_N)
      begin
         bypass_q <= BYPASS_CAPTURE_VAL;
         id_q <= '0;
      end
      else
      begin
         bypass_q <= bypass_d;
         id_q <= id_d;
      end
   end

   // output merge, retimed to the falling edge
   always_comb
   begin
      tdo_oe_d = SHIFT_DR || SHIFT_IR;
      if (SHIFT_IR)
      begin
         tdo_d = IR_SERIAL_OUT;
      end
      else
      begin
         case (dr_sel)
            BSD_SEL_BOUNDARY: tdo_d = chain[N_CELLS];
            BSD_SEL_IDCODE: tdo_d = id_q[0];
            BSD_SEL_BYPASS: tdo_d = bypass_q;
            default: tdo_d = bypass_q;
         endcase
      end
   end

   always_ff @(negedge TEST_CLK or negedge TEST_RESET_N)
   begin
      if (!TEST_RESET_N)
      begin
         tdo_q <= TDO_RESET_VAL;
         tdo_oe_q <= 1'b0;
      end
      else
      begin
         tdo_q <= tdo_d;
         tdo_oe_q <= tdo_oe_d;
      end
   end

   assign TDO = tdo_q;
   assign TDO_OE = tdo_oe_q;

   // EXTEST level into the system domain so the core can hold off its pins
   always_comb
   begin
      ext_meta_d = INSTR_EXTEST;
      ext_sync_d = ext_meta_q;
      if (!RESET_N)
      begin
         ext_meta_d = SYNC_RESET_VAL;
         ext_sync_d = SYNC_RESET_VAL;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      ext_meta_q <= ext_meta_d;
      ext_sync_q <= ext_sync_d;
   end

   assign EXTEST_ACTIVE_SYS = ext_sync_q;

   default clocking cb @(posedge TEST_CLK);
   endclocking
   default disable iff (!TEST_RESET_N);

   a_bypass_loads_zero: assert property (
      CAPTURE_DR |=> (bypass_q == 1'b0))
      else $error("bypass bit not zero after capture");

   a_tdo_idle_hiz: assert property (
      !(SHIFT_DR || SHIFT_IR) |-> !TDO_OE)
      else $error("TDO driven outside shift states");

   a_tdo_bypass_path: assert property (
      (SHIFT_DR && !SHIFT_IR && !INSTR_EXTEST && !INSTR_SAMPLE && !INSTR_IDCODE)
      |-> (TDO_OE && TDO == bypass_q))
      else $error("TDO does not follow bypass bit");

   a_chain_head_shift: assert property (
      (SHIFT_DR && (INSTR_EXTEST || INSTR_SAMPLE)) |=> (chain[1] == $past(TDI)))
      else $error("boundary chain did not take TDI");

   a_chain_parked: assert property (
      (!INSTR_EXTEST && !INSTR_SAMPLE) |=> $stable(chain[N_CELLS]))
      else $error("boundary chain moved while not selected");

   a_extest_drives_pins: assert property (
      INSTR_EXTEST |-> (OUT_PINS == out_upd && BIDIR_OE == oe_upd))
      else $error("pins not from update latches in EXTEST");

   a_mission_pins: assert property (
      !INSTR_EXTEST |-> (OUT_PINS == CORE_OUT && BIDIR_OE == CORE_BIDIR_OE))
      else $error("pins not from core outside EXTEST");

   // one cycle of history first: the latch value before the first edge is unknown
   a_update_only_update: assert property (
      ##1 $changed(out_upd) |-> (UPDATE_DR && (INSTR_EXTEST || INSTR_SAMPLE)))
      else $error("update latch moved outside UPDATE-DR");

   a_obs_capture: assert property (
      (CAPTURE_DR && (INSTR_EXTEST || INSTR_SAMPLE)) |=> (chain[1] == $past(OBS_PINS[0])))
      else $error("observe cell missed pin value");

   a_bidir_core_capture: assert property (
      (CAPTURE_DR && INSTR_SAMPLE && !INSTR_EXTEST && CORE_BIDIR_OE[0])
      |=> (chain[BIDIR_BASE+2] == $past(CORE_BIDIR_OUT[0])))
      else $error("bidir capture missed core data");

   a_bidir_pad_capture: assert property (
      (CAPTURE_DR && (INSTR_EXTEST || (INSTR_SAMPLE && !CORE_BIDIR_OE[0])))
      |=> (chain[BIDIR_BASE+2] == $past(BIDIR_IN[0])))
      else $error("bidir capture missed pad input");

   c_extest_entry: cover property (!INSTR_EXTEST ##1 INSTR_EXTEST);
   c_boundary_shift: cover property ((SHIFT_DR && INSTR_SAMPLE) [*4] ##1 UPDATE_DR);
   c_idcode_shift: cover property (INSTR_IDCODE && CAPTURE_DR ##1 SHIFT_DR [*4]);
   c_bypass_shift: cover property (SHIFT_DR && !INSTR_EXTEST && !INSTR_SAMPLE && !INSTR_IDCODE);

endmodule
`default_nettype wire

/* File: include/bsd_pkg.sv */
package bsd_pkg;

   // chain population of the default pin map
   localparam int NUM_OBS_PINS = 142;
   localparam int NUM_OUT_PINS = 128;
   localparam int NUM_BIDIR_PINS = 36;

   // device identification register
   localparam int ID_WIDTH = 32;
   // arbitrary neutral identification value; bit 0 stays 1 as the scan convention wants
   localparam logic [31:0] ID_VALUE_DEFAULT = 32'h0000_5A01;

   // reset and capture values
   localparam logic BYPASS_CAPTURE_VAL = 1'b0;
   localparam logic CELL_RESET_VAL = 1'b0;
   localparam logic TDO_RESET_VAL = 1'b0;
   localparam logic SYNC_RESET_VAL = 1'b0;

   // data register selected onto the serial output
   typedef enum {
      BSD_SEL_BYPASS,
      BSD_SEL_BOUNDARY,
      BSD_SEL_IDCODE
   } bsd_dr_sel_e;

endpackage

/* File: rtl/bsd_obs_cell.sv */
`timescale 1ns/100ps
`default_nettype none

// observe-only cell: capture and shift stage, never drives anything back
module bsd_obs_cell
   import bsd_pkg::*;
(
   input wire logic tck,
   input wire logic trst_n,
   input wire logic capture_en,
   input wire logic shift_en,
   input wire logic data_in,
   input wire logic serial_in,
   output logic serial_out
);

   logic shift_q;
   logic shift_d;

   always_comb
   begin
      shift_d = shift_q;
      if (capture_en)
      begin
         shift_d = data_in;
      end
      else if (shift_en)
      begin
         shift_d = serial_in;
      end
   end

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         shift_q <= CELL_RESET_VAL;
      end
      else
      begin
         shift_q <= shift_d;
      end
   end

   assign serial_out = shift_q;

endmodule
`default_nettype wire

/* File: rtl/bsd_ctl_cell.sv */
`timescale 1ns/100ps
`default_nettype none

// full output-type cell: shift stage plus a falling-edge update latch
module bsd_ctl_cell
   import bsd_pkg::*;
(
   input wire logic tck,
   input wire logic trst_n,
   input wire logic capture_en,
   input wire logic shift_en,
   input wire logic update_en,
   input wire logic data_in,
   input wire logic serial_in,
   output logic serial_out,
   output logic update_out
);

   logic shift_q;
   logic shift_d;
   logic upd_q;
   logic upd_d;

   always_comb
   begin
      shift_d = shift_q;
      if (capture_en)
      begin
         shift_d = data_in;
      end
      else if (shift_en)
      begin
         shift_d = serial_in;
      end
   end

   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         shift_q <= CELL_RESET_VAL;
      end
      else
      begin
         shift_q <= shift_d;
      end
   end

   // falling edge: skew on the shift path cannot reach the held value
   always_comb
   begin
      upd_d = update_en ? shift_q : upd_q;
   end

   always_ff @(negedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         upd_q <= CELL_RESET_VAL;
      end
      else
      begin
         upd_q <= upd_d;
      end
   end

   assign serial_out = shift_q;
   assign update_out = upd_q;

endmodule
`default_nettype wire

/* File: verif/bsd_tester_model.sv */
`timescale 1ns/100ps
`default_nettype none

// scan tester; the test clock runs only inside a scan and rests high between scans
module bsd_tester_model
(
   output logic tck,
   output logic tdi,
   output logic cap,
   output logic sdr,
   output logic upd,
   output logic sir,
   output logic ir_out,
   input wire logic tdo,
   input wire logic tdo_oe
);
   initial
   begin
      tck = 1'b1;
      tdi = 1'b1;
      {cap, sdr, upd, sir, ir_out} = 5'h00;
   end

   // levels move shortly after a rising edge, tdo is taken just before the next one
   task automatic cyc(input logic [4:0] lv, input logic d, output logic o, output logic oe);
      #1.7;
      {cap, sdr, upd, sir, ir_out} = lv;
      tdi = d;
      #4.3;
      tck = 1'b0;
      #6;
      o = tdo;
      oe = tdo_oe;
      tck = 1'b1;
   endtask

   // capture, n shifts and update for a data scan, n shifts alone when ir is set; idle tdi sits at its pull-up level
   task automatic scan(input bit ir, input logic [63:0] din, input int n,
      output logic [63:0] dout, output bit ok);
      logic o;
      logic oe;
      dout = '0;
      cyc({!ir, 4'h0}, 1'b1, o, oe);
      ok = (oe === 1'b0);
      for (int i = 0; i < n; i++)
      begin
         cyc({1'b0, !ir, 1'b0, ir, ir & din[i]}, ir ? 1'b1 : din[i], o, oe);
         dout[i] = o;
         ok &= (oe === 1'b1);
      end
      cyc({2'h0, !ir, 2'h0}, 1'b1, o, oe);
      cyc(5'h00, 1'b1, o, oe);
      ok &= (oe === 1'b0);
   endtask
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench
   import bsd_pkg::*;
;
   logic SYS_CLK, RESET_N, TEST_RESET_N, INSTR_EXTEST, INSTR_SAMPLE, INSTR_IDCODE;
   logic [1:0] OBS_PINS, CORE_OUT, CORE_BIDIR_OUT, CORE_BIDIR_OE, BIDIR_IN;
   wire logic tck, tdi, cap, sdr, upd, sir, ir_out, TDO, TDO_OE, EXTEST_ACTIVE_SYS;
   wire logic [1:0] CORE_OBS_IN, OUT_PINS, CORE_BIDIR_IN, BIDIR_OUT, BIDIR_OE;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [63:0] din, dout;
   logic [7:0] l;
   logic [9:0] v;
   bit ok;

   bsd_data_path #(.N_OBS(2), .N_OUT(2), .N_BIDIR(2)) i_dut
   (
      .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TEST_CLK(tck), .TEST_RESET_N(TEST_RESET_N),
      .TDI(tdi), .TDO(TDO), .TDO_OE(TDO_OE), .CAPTURE_DR(cap), .SHIFT_DR(sdr),
      .UPDATE_DR(upd), .SHIFT_IR(sir), .IR_SERIAL_OUT(ir_out),
      .INSTR_EXTEST(INSTR_EXTEST), .INSTR_SAMPLE(INSTR_SAMPLE), .INSTR_IDCODE(INSTR_IDCODE),
      .OBS_PINS(OBS_PINS), .CORE_OBS_IN(CORE_OBS_IN), .CORE_OUT(CORE_OUT),
      .OUT_PINS(OUT_PINS), .CORE_BIDIR_OUT(CORE_BIDIR_OUT), .CORE_BIDIR_OE(CORE_BIDIR_OE),
      .CORE_BIDIR_IN(CORE_BIDIR_IN), .BIDIR_IN(BIDIR_IN), .BIDIR_OUT(BIDIR_OUT),
      .BIDIR_OE(BIDIR_OE), .EXTEST_ACTIVE_SYS(EXTEST_ACTIVE_SYS)
   );

   bsd_tester_model i_tst
   (
      .tck(tck), .tdi(tdi), .cap(cap), .sdr(sdr), .upd(upd), .sir(sir),
      .ir_out(ir_out), .tdo(TDO), .tdo_oe(TDO_OE)
   );

   initial
   begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end

   task automatic final_report();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         final_report();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // chain from the serial input: obs0 obs1 out0 out1 en0 cap0 en1 cap1; last leaves first
   // in extest the output and enable cells see their own update latches, lat
   function automatic logic [7:0] exp_cap(input logic ext, input logic [7:0] lat);
      logic [7:0] p;
      p[1:0] = OBS_PINS;
      p[3:2] = ext ? lat[3:2] : CORE_OUT;
      for (int i = 0; i < 2; i++)
      begin
         p[4+2*i] = ext ? lat[4+2*i] : CORE_BIDIR_OE[i];
         p[5+2*i] = (!ext && CORE_BIDIR_OE[i]) ? CORE_BIDIR_OUT[i] : BIDIR_IN[i];
      end
      return {<<{p}};
   endfunction

   task automatic drive(input logic [9:0] x);
      @(negedge SYS_CLK);
      {OBS_PINS, CORE_OUT, CORE_BIDIR_OUT, CORE_BIDIR_OE, BIDIR_IN} = x;
   endtask

   task automatic run(input bit ir, input logic [63:0] d, input int n);
      i_tst.scan(ir, d, n, dout, ok);
      chk(64'(ok), 64'h1, "serial output enable");
   endtask

   initial
   begin
      {RESET_N, TEST_RESET_N, INSTR_EXTEST, INSTR_SAMPLE, INSTR_IDCODE} = 5'h08;
      {OBS_PINS, CORE_OUT, CORE_BIDIR_OUT, CORE_BIDIR_OE, BIDIR_IN} = 10'h000;
      void'($urandom(32'h858A));
      // test reset falls after time zero so its asynchronous edge is never missed
      #1;
      TEST_RESET_N = 1'b0;
      repeat (2) @(negedge SYS_CLK);
      {RESET_N, TEST_RESET_N, INSTR_SAMPLE} = 3'h7;
      chk({TDO_OE, EXTEST_ACTIVE_SYS}, 2'h0, "idle after reset");
      for (int r = 0; r < 6; r++)
      begin
         v = (r == 0) ? 10'h000 : (r == 1) ? 10'h3FF : 10'($urandom);
         drive(v);
         din = {$urandom, $urandom};
         run(0, din, 8);
         chk(dout, 64'(exp_cap(1'b0, 8'h00)), "sample capture");
         chk({CORE_OBS_IN, OUT_PINS, BIDIR_OE, BIDIR_OUT, CORE_BIDIR_IN},
            {OBS_PINS, CORE_OUT, CORE_BIDIR_OE, CORE_BIDIR_OUT, BIDIR_IN}, "pass path");
      end
      // the last sample scan left its random shift data in the update latches before extest
      l = {<<{din[7:0]}};
      @(negedge SYS_CLK);
      {INSTR_SAMPLE, INSTR_EXTEST} = 2'h1;
      #1;
      chk({OUT_PINS, BIDIR_OE, BIDIR_OUT}, {l[3:2], l[6], l[4], l[6], l[4]}, "extest pins");
      repeat (3) @(negedge SYS_CLK);
      chk(EXTEST_ACTIVE_SYS, 1'b1, "extest flag");
      for (int r = 0; r < 3; r++)
      begin
         v = 10'($urandom) | 10'h00C;
         drive(v);
         din = {$urandom, $urandom};
         run(0, din, 8);
         chk(dout, 64'(exp_cap(1'b1, l)), "extest capture");
         l = {<<{din[7:0]}};
         chk({OUT_PINS, BIDIR_OE}, {l[3:2], l[6], l[4]}, "update latch");
         chk(CORE_OBS_IN, OBS_PINS, "observe only");
      end
      @(negedge SYS_CLK);
      INSTR_EXTEST = 1'b0;
      for (int r = 0; r < 3; r++)
      begin
         din = (r == 0) ? 64'hF : 64'($urandom);
         run(0, din, 4);
         chk(dout[3:0], {din[2:0], 1'b0}, "bypass");
      end
      chk(EXTEST_ACTIVE_SYS, 1'b0, "extest flag clear");
      @(negedge SYS_CLK);
      INSTR_IDCODE = 1'b1;
      run(0, 64'h0, 32);
      chk(dout[31:0], ID_VALUE_DEFAULT, "identification");
      @(negedge SYS_CLK);
      INSTR_IDCODE = 1'b0;
      din = 64'($urandom);
      run(1, din, 8);
      chk(dout[7:0], din[7:0], "instruction shift");
      @(negedge SYS_CLK);
      INSTR_EXTEST = 1'b1;
      TEST_RESET_N = 1'b0;
      #1;
      chk({OUT_PINS, BIDIR_OE, TDO_OE}, 5'h00, "test reset");
      @(negedge SYS_CLK);
      TEST_RESET_N = 1'b1;
      final_report();
   end
endmodule

`default_nettype wire
